// *** common/mps_pkg.sv ***
// Constants and types shared by the multiplex pump stager
package mps_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int MPS_PW = 16;
  localparam int MPS_FW = 16;
  localparam int MPS_TW = 16;

  // ---------------------------------------------------------------
  // Unit codes
  // ---------------------------------------------------------------
  localparam logic [1:0] MPS_UNIT_MASTER = 2'h0;
  localparam logic [1:0] MPS_UNIT_SLAVE1 = 2'h1;
  localparam logic [1:0] MPS_UNIT_SLAVE2 = 2'h2;

  // ---------------------------------------------------------------
  // Configuration codes
  // ---------------------------------------------------------------
  localparam logic [3:0] MPS_RELAY1_AUX_SEL = 4'h6;
  localparam logic [1:0] MPS_MAX_LAG = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int MPS_CLK_PERIOD_NS = 10;
  localparam int MPS_TICK_PERIOD_NS = 1000000;
  localparam int MPS_TICK_CYCLES = MPS_TICK_PERIOD_NS / MPS_CLK_PERIOD_NS;
  localparam int MPS_MS_PER_SEC = 1000;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] MPS_UNITS_RST = 3'h0;
  localparam logic [1:0] MPS_PRIMARY_RST = 2'h0;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MPS_ST_RUN = 2'b00,
    MPS_ST_STAGE_SETTLE = 2'b01,
    MPS_ST_DESTAGE_SETTLE = 2'b10
  } mps_state_t;

endpackage : mps_pkg

// *** design/mps_stager.sv ***
// Multiplex pump staging controller: rotation, stage and sleep decisions
`timescale 1ns/10ps
module mps_stager #(
  parameter int TICK_CYCLES = mps_pkg::MPS_TICK_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [1:0] lag_count_in,
  input wire logic [mps_pkg::MPS_TW-1:0] rotation_period_s_in,
  input wire logic [3:0] relay1_func_in,
  input wire logic [mps_pkg::MPS_PW-1:0] pressure_in,
  input wire logic [mps_pkg::MPS_PW-1:0] pressure_target_in,
  input wire logic [mps_pkg::MPS_PW-1:0] stage_pressure_offset_in,
  input wire logic [mps_pkg::MPS_PW-1:0] destage_pressure_offset_in,
  input wire logic [mps_pkg::MPS_TW-1:0] stage_hold_delay_ms_in,
  input wire logic [mps_pkg::MPS_TW-1:0] destage_hold_delay_ms_in,
  input wire logic [mps_pkg::MPS_FW-1:0] master_freq_in,
  input wire logic [mps_pkg::MPS_FW-1:0] max_freq_in,
  input wire logic [mps_pkg::MPS_FW-1:0] floor_freq_in,
  input wire logic [mps_pkg::MPS_FW-1:0] destage_speed_band_in,
  input wire logic [mps_pkg::MPS_FW-1:0] stage_speed_cut1_in,
  input wire logic [mps_pkg::MPS_FW-1:0] stage_speed_cut2_in,
  input wire logic [mps_pkg::MPS_TW-1:0] stage_settle_ms1_in,
  input wire logic [mps_pkg::MPS_TW-1:0] stage_settle_ms2_in,
  input wire logic [mps_pkg::MPS_FW-1:0] destage_speed_lift_in,
  input wire logic [mps_pkg::MPS_TW-1:0] destage_settle_time_ms_in,
  input wire logic [mps_pkg::MPS_FW-1:0] sleep_speed_margin_in,
  input wire logic [mps_pkg::MPS_TW-1:0] min_run_time_one_ms_in,
  input wire logic [mps_pkg::MPS_TW-1:0] min_run_time_two_ms_in,
  input wire logic run_time_sel_in,
  output logic active_out,
  output logic [1:0] relay_out,
  output logic master_awake_out,
  output logic speed_override_en_out,
  output logic [mps_pkg::MPS_FW-1:0] speed_override_out,
  output logic [1:0] primary_out,
  output logic sleep_ok_out
);
  import mps_pkg::*;

  // ---------------------------------------------------------------
  // Millisecond and second enables
  // ---------------------------------------------------------------
  logic [31:0] div_q, div_d;
  logic tick_ms;
  logic [9:0] ms_q, ms_d;
  logic tick_s;

  always_comb begin
    tick_ms = (div_q == 32'(TICK_CYCLES - 1));
    div_d = tick_ms ? 32'h0 : div_q + 32'h1;
    tick_s = tick_ms && (ms_q == 10'(MPS_MS_PER_SEC - 1));
    ms_d = ms_q;
    if (tick_s) begin
      ms_d = 10'h0;
    end else if (tick_ms) begin
      ms_d = ms_q + 10'h1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      div_q <= 32'h0;
      ms_q <= 10'h0;
    end else begin
      div_q <= div_d;
      ms_q <= ms_d;
    end
  end

  // ---------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------
  logic active;
  logic relay1_excl;
  logic [1:0] lag;

  always_comb begin
    active = (lag_count_in != 2'h0) && (rotation_period_s_in != '0);
    relay1_excl = (relay1_func_in == MPS_RELAY1_AUX_SEL);
    lag = (lag_count_in > MPS_MAX_LAG) ? MPS_MAX_LAG : lag_count_in;
  end

  // ---------------------------------------------------------------
  // Primary rotation
  // ---------------------------------------------------------------
  logic [1:0] primary_q, primary_d;
  logic [MPS_TW-1:0] rot_cnt_q, rot_cnt_d;

  always_comb begin
    primary_d = primary_q;
    rot_cnt_d = rot_cnt_q;
    if (!active) begin
      primary_d = MPS_UNIT_MASTER;
      rot_cnt_d = '0;
    end else if (tick_s) begin
      if (rot_cnt_q + 16'h1 >= rotation_period_s_in) begin
        rot_cnt_d = '0;
        primary_d = (primary_q >= lag) ? MPS_UNIT_MASTER
                                       : primary_q + 2'h1;
        if (primary_d == MPS_UNIT_SLAVE1 && relay1_excl) begin
          primary_d = (lag == MPS_MAX_LAG) ? MPS_UNIT_SLAVE2
                                           : MPS_UNIT_MASTER;
        end
      end else begin
        rot_cnt_d = rot_cnt_q + 16'h1;
      end
    end
    if (primary_d == MPS_UNIT_SLAVE1 && relay1_excl) begin
      primary_d = MPS_UNIT_MASTER;
    end
    if (primary_d > lag) begin
      primary_d = MPS_UNIT_MASTER;
    end
  end

  // ---------------------------------------------------------------
  // Staging order for the current primary
  // ---------------------------------------------------------------
  logic [1:0] order [3];
  logic [1:0] order_len;
  logic [2:0] units_q, units_d;
  logic [1:0] next_unit, last_unit;
  logic can_stage, can_destage, next_is_primary;

  always_comb begin
    order[0] = primary_q;
    order[1] = MPS_UNIT_SLAVE1;
    order[2] = MPS_UNIT_SLAVE2;
    if (primary_q != MPS_UNIT_MASTER) begin
      order[1] = MPS_UNIT_MASTER;
      order[2] = (primary_q == MPS_UNIT_SLAVE1) ? MPS_UNIT_SLAVE2
                                                 : MPS_UNIT_SLAVE1;
    end
    order_len = lag + 2'h1;
    if (relay1_excl) begin
      if (order[1] == MPS_UNIT_SLAVE1) begin
        order[1] = order[2];
      end
      order_len = order_len - 2'h1;
    end
    can_stage = 1'b0;
    next_unit = MPS_UNIT_MASTER;
    next_is_primary = 1'b0;
    for (int i = 2; i >= 0; i--) begin
      if (2'(i) < order_len && !units_q[order[i]]) begin
        can_stage = 1'b1;
        next_unit = order[i];
        next_is_primary = (i == 0);
      end
    end
    can_destage = 1'b0;
    last_unit = MPS_UNIT_MASTER;
    for (int i = 0; i < 3; i++) begin
      if (2'(i) < order_len && units_q[order[i]]) begin
        can_destage = 1'b1; // Reverse order: last staged goes first
        last_unit = order[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Pressure, frequency and sleep conditions
  // ---------------------------------------------------------------
  logic stage_press, destage_press, destage_freq;
  logic sleep_press, sleep_freq;
  logic [MPS_TW-1:0] min_run;

  always_comb begin
    stage_press = ({1'b0, pressure_in} + {1'b0, stage_pressure_offset_in})
                  <= {1'b0, pressure_target_in};
    destage_press = {1'b0, pressure_in} >=
                    ({1'b0, pressure_target_in} +
                     {1'b0, destage_pressure_offset_in});
    destage_freq = (master_freq_in >= floor_freq_in) &&
                   ({1'b0, master_freq_in} <=
                    ({1'b0, floor_freq_in} +
                     {1'b0, destage_speed_band_in}));
    sleep_press = (pressure_in >= pressure_target_in);
    sleep_freq = ({1'b0, master_freq_in} <=
                  ({1'b0, floor_freq_in} +
                   {1'b0, sleep_speed_margin_in}));
    min_run = run_time_sel_in ? min_run_time_two_ms_in
                              : min_run_time_one_ms_in;
  end

  // ---------------------------------------------------------------
  // Hold timers and run timer
  // ---------------------------------------------------------------
  logic [MPS_TW-1:0] stage_hold_q, stage_hold_d;
  logic [MPS_TW-1:0] destage_hold_q, destage_hold_d;
  logic [MPS_TW-1:0] run_q, run_d;
  logic run_sat;

  always_comb begin
    stage_hold_d = stage_hold_q;
    destage_hold_d = destage_hold_q;
    run_d = run_q;
    run_sat = (run_q == '1);
    if (!stage_press) begin
      stage_hold_d = '0;
    end else if (tick_ms && stage_hold_q != '1) begin
      stage_hold_d = stage_hold_q + 16'h1;
    end
    if (!(destage_press && destage_freq)) begin
      destage_hold_d = '0;
    end else if (tick_ms && destage_hold_q != '1) begin
      destage_hold_d = destage_hold_q + 16'h1;
    end
    if (!units_q[MPS_UNIT_MASTER]) begin
      run_d = '0;
    end else if (tick_ms && !run_sat) begin
      run_d = run_q + 16'h1;
    end
  end

  logic sleep_ok_full;
  assign sleep_ok_full = sleep_press && sleep_freq &&
                         (run_q > min_run);

  // ---------------------------------------------------------------
  // Stage and destage sequencer
  // ---------------------------------------------------------------
  mps_state_t state_q, state_d;
  logic [MPS_TW-1:0] settle_q, settle_d;
  logic ovr_en_d;
  logic [MPS_FW-1:0] ovr_d, ovr_q;
  logic do_stage, do_destage;

  always_comb begin
    state_d = state_q;
    settle_d = settle_q;
    units_d = units_q;
    ovr_d = ovr_q;
    ovr_en_d = 1'b0;
    do_stage = 1'b0;
    do_destage = 1'b0;
    unique case (state_q)
      MPS_ST_RUN: begin
        do_stage = can_stage && stage_press &&
                   (next_is_primary ||
                    stage_hold_q >= stage_hold_delay_ms_in);
        do_destage = !do_stage && can_destage && destage_press &&
                     destage_freq &&
                     destage_hold_q >= destage_hold_delay_ms_in &&
                     (last_unit != MPS_UNIT_MASTER || sleep_ok_full);
        if (do_stage) begin
          units_d[next_unit] = 1'b1;
          if (next_unit != MPS_UNIT_MASTER) begin
            state_d = MPS_ST_STAGE_SETTLE;
            settle_d = (next_unit == MPS_UNIT_SLAVE1) ? stage_settle_ms1_in
                                                      : stage_settle_ms2_in;
            ovr_d = max_freq_in - ((next_unit == MPS_UNIT_SLAVE1)
                    ? stage_speed_cut1_in : stage_speed_cut2_in);
          end
        end else if (do_destage) begin
          units_d[last_unit] = 1'b0;
          state_d = MPS_ST_DESTAGE_SETTLE;
          settle_d = destage_settle_time_ms_in;
          ovr_d = master_freq_in + destage_speed_lift_in;
        end
      end
      MPS_ST_STAGE_SETTLE, MPS_ST_DESTAGE_SETTLE: begin
        ovr_en_d = 1'b1;
        if (settle_q == '0) begin
          state_d = MPS_ST_RUN;
          ovr_en_d = 1'b0;
        end else if (tick_ms) begin
          settle_d = settle_q - 16'h1;
        end
      end
      default: begin
        state_d = MPS_ST_RUN;
      end
    endcase
    if (state_d != MPS_ST_RUN) begin
      ovr_en_d = 1'b1;
    end
    if (!active) begin
      state_d = MPS_ST_RUN;
      units_d = MPS_UNITS_RST;
      ovr_en_d = 1'b0;
    end
    if (relay1_excl) begin
      units_d[MPS_UNIT_SLAVE1] = 1'b0;
    end
    if (lag < MPS_MAX_LAG) begin
      units_d[MPS_UNIT_SLAVE2] = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State registers and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      primary_q <= MPS_PRIMARY_RST;
      rot_cnt_q <= '0;
      units_q <= MPS_UNITS_RST;
      stage_hold_q <= '0;
      destage_hold_q <= '0;
      run_q <= '0;
      state_q <= MPS_ST_RUN;
      settle_q <= '0;
      ovr_q <= '0;
      active_out <= 1'b0;
      relay_out <= 2'h0;
      master_awake_out <= 1'b0;
      speed_override_en_out <= 1'b0;
      speed_override_out <= '0;
      primary_out <= MPS_PRIMARY_RST;
      sleep_ok_out <= 1'b0;
    end else begin
      primary_q <= primary_d;
      rot_cnt_q <= rot_cnt_d;
      units_q <= units_d;
      stage_hold_q <= (do_stage || do_destage) ? '0 : stage_hold_d;
      destage_hold_q <= (do_stage || do_destage) ? '0 : destage_hold_d;
      run_q <= run_d;
      state_q <= state_d;
      settle_q <= settle_d;
      ovr_q <= ovr_d;
      active_out <= active;
      relay_out <= units_d[2:1];
      master_awake_out <= units_d[MPS_UNIT_MASTER];
      speed_override_en_out <= ovr_en_d;
      speed_override_out <= ovr_d;
      primary_out <= primary_d;
      sleep_ok_out <= sleep_ok_full;
    end
  end

endmodule : mps_stager

// *** verification/mps_stager_sva.sv ***
// Port-level concurrent checks for the pump stager
`timescale 1ns/10ps
module mps_stager_sva (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [1:0] lag_count_in,
  input wire logic [mps_pkg::MPS_TW-1:0] rotation_period_s_in,
  input wire logic [3:0] relay1_func_in,
  input wire logic [mps_pkg::MPS_PW-1:0] pressure_in,
  input wire logic [mps_pkg::MPS_PW-1:0] pressure_target_in,
  input wire logic [mps_pkg::MPS_PW-1:0] stage_pressure_offset_in,
  input wire logic [mps_pkg::MPS_PW-1:0] destage_pressure_offset_in,
  input wire logic [mps_pkg::MPS_FW-1:0] master_freq_in,
  input wire logic [mps_pkg::MPS_FW-1:0] max_freq_in,
  input wire logic [mps_pkg::MPS_FW-1:0] floor_freq_in,
  input wire logic [mps_pkg::MPS_FW-1:0] destage_speed_band_in,
  input wire logic [mps_pkg::MPS_FW-1:0] stage_speed_cut1_in,
  input wire logic [mps_pkg::MPS_FW-1:0] destage_speed_lift_in,
  input wire logic [mps_pkg::MPS_FW-1:0] sleep_speed_margin_in,
  input wire logic active_out,
  input wire logic [1:0] relay_out,
  input wire logic master_awake_out,
  input wire logic speed_override_en_out,
  input wire logic [mps_pkg::MPS_FW-1:0] speed_override_out,
  input wire logic [1:0] primary_out,
  input wire logic sleep_ok_out
);
  import mps_pkg::*;
  logic on_w;
  logic low_w;
  logic high_w;
  logic band_w;
  logic slp_w;
  // ---------------------------------------------------------------
  // Threshold helpers, widened so sums cannot wrap
  // ---------------------------------------------------------------
  assign on_w = (lag_count_in != 2'h0) && (rotation_period_s_in != 16'h0);
  assign low_w = {1'b0, pressure_in} + {1'b0, stage_pressure_offset_in}
    <= {1'b0, pressure_target_in};
  assign high_w = {1'b0, pressure_in}
    >= {1'b0, pressure_target_in} + {1'b0, destage_pressure_offset_in};
  assign band_w = (master_freq_in >= floor_freq_in) && ({1'b0, master_freq_in}
    <= {1'b0, floor_freq_in} + {1'b0, destage_speed_band_in});
  assign slp_w = (pressure_in >= pressure_target_in) && ({1'b0, master_freq_in}
    <= {1'b0, floor_freq_in} + {1'b0, sleep_speed_margin_in});
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_off_clears;
    !on_w |=> !active_out && relay_out == 2'h0 && !master_awake_out;
  endproperty
  a_off_clears: assert property (p_off_clears)
    else $error("units kept while inactive");
  property p_stage_low;
    $rose(relay_out[0]) || $rose(relay_out[1]) || $rose(master_awake_out)
      |-> $past(low_w);
  endproperty
  a_stage_low: assert property (p_stage_low)
    else $error("unit staged without low pressure");
  property p_stage_cut;
    $rose(relay_out[0]) |-> speed_override_en_out &&
      speed_override_out == $past(max_freq_in - stage_speed_cut1_in);
  endproperty
  a_stage_cut: assert property (p_stage_cut)
    else $error("stage speed cut wrong");
  property p_destage_cond;
    ($fell(relay_out[0]) || $fell(relay_out[1])) && $past(on_w)
      |-> $past(high_w && band_w);
  endproperty
  a_destage_cond: assert property (p_destage_cond)
    else $error("slave destaged without its conditions");
  property p_destage_lift;
    ($fell(relay_out[0]) || $fell(relay_out[1])) && $past(on_w)
      |-> speed_override_en_out &&
      speed_override_out == $past(master_freq_in + destage_speed_lift_in);
  endproperty
  a_destage_lift: assert property (p_destage_lift)
    else $error("destage speed lift wrong");
  property p_settle_hold;
    speed_override_en_out && on_w |=>
      $stable(relay_out) && $stable(master_awake_out);
  endproperty
  a_settle_hold: assert property (p_settle_hold)
    else $error("decision during settle");
  property p_master_plain;
    $rose(master_awake_out) |-> !speed_override_en_out;
  endproperty
  a_master_plain: assert property (p_master_plain)
    else $error("override after master wake");
  property p_sleep_ok;
    sleep_ok_out |-> $past(slp_w);
  endproperty
  a_sleep_ok: assert property (p_sleep_ok)
    else $error("sleep flagged without conditions");
  property p_aux_skip;
    $rose(relay_out[0]) |-> $past(relay1_func_in) != MPS_RELAY1_AUX_SEL;
  endproperty
  a_aux_skip: assert property (p_aux_skip)
    else $error("excluded relay 1 staged");
  property p_aux_primary;
    $changed(primary_out) && $past(relay1_func_in) == MPS_RELAY1_AUX_SEL
      |-> primary_out != MPS_UNIT_SLAVE1;
  endproperty
  a_aux_primary: assert property (p_aux_primary)
    else $error("excluded relay 1 made primary");
  c_stage_two: cover property ($rose(relay_out[1]));
  c_destage: cover property ($fell(relay_out[0]) && on_w);
  c_rotate: cover property ($changed(primary_out));
endmodule : mps_stager_sva

bind mps_stager mps_stager_sva mps_stager_sva_i (
  .clk_sys_in, .sys_rst_in, .lag_count_in, .rotation_period_s_in,
  .relay1_func_in, .pressure_in, .pressure_target_in,
  .stage_pressure_offset_in, .destage_pressure_offset_in, .master_freq_in,
  .max_freq_in, .floor_freq_in, .destage_speed_band_in,
  .stage_speed_cut1_in, .destage_speed_lift_in, .sleep_speed_margin_in,
  .active_out, .relay_out, .master_awake_out, .speed_override_en_out,
  .speed_override_out, .primary_out, .sleep_ok_out
);

// *** verification/mps_slave_model.sv ***
// Relay-switched slave drives on the stager's far side
`timescale 1ns/10ps
module mps_slave_model (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [1:0] relay_in,
  output logic [1:0] running_out
);
  logic [7:0] dly_q;
  logic [7:0] dly_d;
  always_comb begin
    dly_d = {dly_q[5:0], relay_in};
  end
  always_ff @(posedge clk_sys_in) begin
    dly_q <= sys_rst_in ? 8'h00 : dly_d;
  end
  // Starts four cycles after relay close, stops at once on open
  assign running_out = dly_q[7:6] & relay_in;
endmodule : mps_slave_model

// *** verification/testbench.sv ***
// Self-checking bench for the pump stager
`timescale 1ns/10ps
module testbench;
  import mps_pkg::*;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [1:0] lag_count_in = 2'h0;
  logic [MPS_TW-1:0] rotation_period_s_in = 16'h0001;
  logic [3:0] relay1_func_in = 4'h0;
  logic [MPS_PW-1:0] pressure_in = 16'h0032;
  logic [MPS_PW-1:0] pressure_target_in = 16'h0032;
  logic [MPS_PW-1:0] stage_pressure_offset_in = 16'h0005;
  logic [MPS_PW-1:0] destage_pressure_offset_in = 16'h0005;
  logic [MPS_TW-1:0] stage_hold_delay_ms_in = 16'h0003;
  logic [MPS_TW-1:0] destage_hold_delay_ms_in = 16'h0003;
  logic [MPS_FW-1:0] master_freq_in = 16'h0028;
  logic [MPS_FW-1:0] max_freq_in = 16'h003C;
  logic [MPS_FW-1:0] floor_freq_in = 16'h001E;
  logic [MPS_FW-1:0] destage_speed_band_in = 16'h0005;
  logic [MPS_FW-1:0] stage_speed_cut1_in = 16'h0005;
  logic [MPS_FW-1:0] stage_speed_cut2_in = 16'h0007;
  logic [MPS_TW-1:0] stage_settle_ms1_in = 16'h0001;
  logic [MPS_TW-1:0] stage_settle_ms2_in = 16'h0001;
  logic [MPS_FW-1:0] destage_speed_lift_in = 16'h0003;
  logic [MPS_TW-1:0] destage_settle_time_ms_in = 16'h0001;
  logic [MPS_FW-1:0] sleep_speed_margin_in = 16'h0002;
  logic [MPS_TW-1:0] min_run_time_one_ms_in = 16'h0001;
  logic [MPS_TW-1:0] min_run_time_two_ms_in = 16'h7FFF;
  logic run_time_sel_in = 1'b0;
  logic active_out, master_awake_out, speed_override_en_out, sleep_ok_out;
  logic [1:0] relay_out, primary_out, running_out;
  logic [MPS_FW-1:0] speed_override_out;
  int bad_count = 0;
  int checks_done = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  mps_stager #(.TICK_CYCLES(10)) mps_stager_i (
    .clk_sys_in, .sys_rst_in, .lag_count_in, .rotation_period_s_in,
    .relay1_func_in, .pressure_in, .pressure_target_in,
    .stage_pressure_offset_in, .destage_pressure_offset_in,
    .stage_hold_delay_ms_in, .destage_hold_delay_ms_in, .master_freq_in,
    .max_freq_in, .floor_freq_in, .destage_speed_band_in,
    .stage_speed_cut1_in, .stage_speed_cut2_in, .stage_settle_ms1_in,
    .stage_settle_ms2_in, .destage_speed_lift_in,
    .destage_settle_time_ms_in, .sleep_speed_margin_in,
    .min_run_time_one_ms_in, .min_run_time_two_ms_in, .run_time_sel_in,
    .active_out, .relay_out, .master_awake_out, .speed_override_en_out,
    .speed_override_out, .primary_out, .sleep_ok_out);
  mps_slave_model mps_slave_model_i (.clk_sys_in, .sys_rst_in,
    .relay_in(relay_out), .running_out);
  // ---------------------------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : wt
  task automatic drv(input logic [15:0] p, input logic [15:0] f);
    @(posedge clk_sys_in);
    pressure_in <= p;
    master_freq_in <= f;
    #1;
  endtask : drv
  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_v
  task automatic chk_b(input logic [2:0] got, input logic [2:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t units %b expected %b", $time, got, exp);
    end
  endtask : chk_b
  // Units as {master, slave2, slave1}, waited for under a bound
  task automatic wu(input logic [2:0] exp, input int n);
    int k;
    k = 0;
    while ({master_awake_out, relay_out} !== exp && k < n) begin
      wt(1);
      k++;
    end
    chk_b({master_awake_out, relay_out}, exp);
  endtask : wu
  task automatic rot(input logic [1:0] exp);
    logic [1:0] old;
    int k;
    old = primary_out;
    k = 0;
    while (primary_out === old && k < 12000) begin
      wt(1);
      k++;
    end
    chk_b({1'b0, primary_out}, {1'b0, exp});
  endtask : rot
  task automatic close_out;
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    bad_count++;
    close_out();
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    wt(3);
    chk_b({2'h0, active_out}, 3'h0);
    @(posedge clk_sys_in);
    lag_count_in <= 2'h2;
    wt(3);
    chk_b({2'h0, active_out}, 3'h1);
    drv(16'h002C, 16'h0028);
    wu(3'b100, 4);
    chk_b({2'h0, speed_override_en_out}, 3'h0);
    wt(12);
    chk_b({master_awake_out, relay_out}, 3'b100);
    wu(3'b101, 60);
    chk_v(speed_override_out, 16'h0037);
    drv(16'h0032, 16'h0028);
    wt(14);
    chk_b({2'h0, speed_override_en_out}, 3'h0);
    drv(16'h002C, 16'h0028);
    wt(12);
    drv(16'h0032, 16'h0028);
    wt(50);
    chk_b({master_awake_out, relay_out}, 3'b101);
    drv(16'h002C, 16'h0028);
    wu(3'b111, 60);
    chk_v(speed_override_out, 16'h0035);
    drv(16'h0038, 16'h0028);
    wt(60);
    chk_b({master_awake_out, relay_out}, 3'b111);
    chk_b({1'b0, running_out}, 3'h3);
    drv(16'h0038, 16'h0020);
    wu(3'b101, 60);
    chk_v(speed_override_out, 16'h0023);
    wu(3'b100, 80);
    drv(16'h0038, 16'h0028);
    wt(3);
    chk_b({2'h0, sleep_ok_out}, 3'h0);
    drv(16'h0038, 16'h0020);
    wt(3);
    chk_b({2'h0, sleep_ok_out}, 3'h1);
    @(posedge clk_sys_in);
    run_time_sel_in <= 1'b1;
    wt(3);
    chk_b({2'h0, sleep_ok_out}, 3'h0);
    @(posedge clk_sys_in);
    run_time_sel_in <= 1'b0;
    drv(16'h0031, 16'h0020);
    wt(3);
    chk_b({2'h0, sleep_ok_out}, 3'h0);
    drv(16'h0038, 16'h0020);
    wu(3'b000, 80);
    drv(16'h0032, 16'h0028);
    rot(2'h1);
    @(posedge clk_sys_in);
    lag_count_in <= 2'h1;
    drv(16'h002C, 16'h0028);
    wu(3'b001, 4);
    wu(3'b101, 80);
    drv(16'h0038, 16'h0020);
    wu(3'b001, 80);
    wu(3'b000, 80);
    drv(16'h0032, 16'h0028);
    rot(2'h0);
    @(posedge clk_sys_in);
    relay1_func_in <= MPS_RELAY1_AUX_SEL;
    lag_count_in <= 2'h2;
    rot(2'h2);
    drv(16'h002C, 16'h0028);
    wu(3'b010, 4);
    wu(3'b110, 80);
    wt(60);
    chk_b({master_awake_out, relay_out}, 3'b110);
    @(posedge clk_sys_in);
    rotation_period_s_in <= 16'h0000;
    wt(3);
    chk_b({master_awake_out, relay_out}, 3'b000);
    chk_b({2'h0, active_out}, 3'h0);
    close_out();
  end
endmodule : testbench
